// ### verilog/hpc_consts.svh
// Functional notes
// - mapping mode 00 selects three-wire selector among 8 preset configurations.
// - mapping mode 01 selects four-wire direct control, level sensitive.
// - mapping mode 10 selects four-wire edge control, never unassigned.
// - mapping mode 11 selects four-wire edge control with unassigned state.
// - source bit clear uses select pins; set uses assignment registers.
// - indicator codes 00 and 11 both give standard port indication.
// - indicator code 01 shows owning host and connection speed.
// - indicator code 10 shows only owning host.
// - third configuration byte bit 0 enables string descriptors.
// - fixed-port mask bits 4..1 mark ports 4..1 non-removable.
// - active ports with permanent devices are reported to the host.
// - with internal defaults, fixed-port straps choose non-removable ports.
// - self-powered, masked ports stay permanently disabled.
// - with internal defaults, port-off straps choose disabled ports.
// - reserved bits of the three registers always read zero.
`ifndef HPC_CONSTS_SVH
`define HPC_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define HPC_OFF_CONFIG_BYTE_THREE 8'h08
`define HPC_OFF_FIXED_PORT_MASK 8'h09
`define HPC_OFF_SELF_POWERED_PORT_OFF_MASK 8'h0A

// ----------------------------------------------------------------
// field positions, writable masks and reset values
// ----------------------------------------------------------------
`define HPC_MAP_MODE_HI 7
`define HPC_MAP_MODE_LO 6
`define HPC_MAP_SOURCE_BIT 5
`define HPC_IND_MODE_HI 2
`define HPC_IND_MODE_LO 1
`define HPC_STRING_EN_BIT 0
`define HPC_CFG3_WR_MASK 8'hE7
`define HPC_PORT_WR_MASK 8'h1E
`define HPC_RESET_VALUE 8'h00

// ----------------------------------------------------------------
// strap input synchroniser depth
// ----------------------------------------------------------------
`define HPC_SYNC_STAGES 3

`endif

// ### verilog/hpc_pkg.sv
package hpc_pkg;

    // host assignment interface modes
    typedef enum logic [1:0] {
        HPC_MAP_PROGRAMMABLE = 2'b00,
        HPC_MAP_DIRECT_LEVEL = 2'b01,
        HPC_MAP_DIRECT_EDGE = 2'b10,
        HPC_MAP_DIRECT_EDGE_UNASSIGNED = 2'b11
    } hpc_map_mode_e;

    // port indicator modes
    typedef enum logic [1:0] {
        HPC_IND_USB = 2'b00,
        HPC_IND_HOST_SPEED = 2'b01,
        HPC_IND_HOST_ONLY = 2'b10,
        HPC_IND_USB_ALT = 2'b11
    } hpc_ind_mode_e;

    // loader phase
    typedef enum logic [0:0] {
        HPC_ST_LOADING = 1'b0,
        HPC_ST_APPLIED = 1'b1
    } hpc_state_e;

endpackage : hpc_pkg

// ### verilog/hpc_port_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "hpc_consts.svh"

module hpc_port_config_regs
    import hpc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // configuration loader byte port
    input wire logic cfg_wr_en,
    input wire logic cfg_rd_en,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wr_data,
    output logic [7:0] cfg_rd_data,
    // loader status
    input wire logic use_internal_default,
    input wire logic config_done,
    input wire logic self_powered,
    // strap pins
    input wire logic [1:0] fixed_port_strap,
    input wire logic [1:0] port_off_strap,
    // host assignment interface setup
    output logic [1:0] port_map_interface_mode,
    output logic map_three_wire,
    output logic map_level_sensitive,
    output logic map_edge_sensitive,
    output logic map_unassigned_allowed,
    output logic port_map_source_select,
    // indicator setup
    output logic ind_usb_mode,
    output logic ind_host_and_speed,
    output logic ind_host_only,
    // descriptors and ports
    output logic string_support_en,
    output logic [3:0] port_fixed,
    output logic [3:0] port_off,
    output logic config_applied
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // thermometer from port 1 upward: 0 none, 1 port1, 2 ports1-2, 3 ports1-3
    function automatic logic [3:0] hpc_low_ports(input logic [1:0] code);
        case (code)
            2'b00: hpc_low_ports = 4'b0000;
            2'b01: hpc_low_ports = 4'b0001;
            2'b10: hpc_low_ports = 4'b0011;
            default: hpc_low_ports = 4'b0111;
        endcase
    endfunction : hpc_low_ports

    // contiguous from port 4 downward, matching the only legal disable patterns
    function automatic logic [3:0] hpc_high_ports(input logic [1:0] code);
        case (code)
            2'b00: hpc_high_ports = 4'b0000;
            2'b01: hpc_high_ports = 4'b1000;
            2'b10: hpc_high_ports = 4'b1100;
            default: hpc_high_ports = 4'b1110;
        endcase
    endfunction : hpc_high_ports

    // host assignment mode field, decoded once for both the raw copy and the flags
    function automatic hpc_map_mode_e hpc_map_field(input logic [7:0] cfg);
        hpc_map_field = hpc_map_mode_e'(cfg[`HPC_MAP_MODE_HI:`HPC_MAP_MODE_LO]);
    endfunction : hpc_map_field

    // indicator mode field; codes 00 and 11 are told apart here and merged below
    function automatic hpc_ind_mode_e hpc_ind_field(input logic [7:0] cfg);
        hpc_ind_field = hpc_ind_mode_e'(cfg[`HPC_IND_MODE_HI:`HPC_IND_MODE_LO]);
    endfunction : hpc_ind_field

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [7:0] config_byte_three;
    logic [7:0] fixed_port_mask;
    logic [7:0] self_powered_port_off_mask;
    hpc_state_e state;
    logic [1:0] fixed_sync1, fixed_sync2, fixed_sync3, fixed_strap_stable;
    logic [1:0] off_sync1, off_sync2, off_sync3, off_strap_stable;
    logic [3:0] applied_off;
    logic loading;
    logic apply_now;

    assign loading = (state == HPC_ST_LOADING);

    // the single cycle in which the loaded image is taken; every decode samples here
    assign apply_now = loading && config_done;

    // strap pins come from the board: three stages, accept once stages two and three agree
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            fixed_sync1 <= 2'b00;
            fixed_sync2 <= 2'b00;
            fixed_sync3 <= 2'b00;
            off_sync1 <= 2'b00;
            off_sync2 <= 2'b00;
            off_sync3 <= 2'b00;
        end else begin
            fixed_sync1 <= fixed_port_strap;
            fixed_sync2 <= fixed_sync1;
            fixed_sync3 <= fixed_sync2;
            off_sync1 <= port_off_strap;
            off_sync2 <= off_sync1;
            off_sync3 <= off_sync2;
        end
    end

    // filtered strap levels; a single-cycle glitch never reaches them
    // limitation: a strap that keeps toggling never settles, the last agreed value stands
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            fixed_strap_stable <= 2'b00;
            off_strap_stable <= 2'b00;
        end else begin
            if (fixed_sync2 == fixed_sync3) begin
                fixed_strap_stable <= fixed_sync3;
            end
            if (off_sync2 == off_sync3) begin
                off_strap_stable <= off_sync3;
            end
        end
    end

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    // writes only land while loading; afterwards the image is frozen so a stray
    // access cannot move a port mid-enumeration
    // reserved bits are stripped on the way in, so the read path needs no masking
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            config_byte_three <= `HPC_RESET_VALUE;
            fixed_port_mask <= `HPC_RESET_VALUE;
            self_powered_port_off_mask <= `HPC_RESET_VALUE;
        end else if (cfg_wr_en && loading) begin
            case (cfg_addr)
                `HPC_OFF_CONFIG_BYTE_THREE: begin
                    config_byte_three <= cfg_wr_data & `HPC_CFG3_WR_MASK;
                end
                `HPC_OFF_FIXED_PORT_MASK: begin
                    fixed_port_mask <= cfg_wr_data & `HPC_PORT_WR_MASK;
                end
                `HPC_OFF_SELF_POWERED_PORT_OFF_MASK: begin
                    self_powered_port_off_mask <= cfg_wr_data & `HPC_PORT_WR_MASK;
                end
                default: begin
                end
            endcase
        end
    end

    // registered read; unmapped offsets answer zero
    // reads stay open after apply so the loader can verify what the hub runs with
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cfg_rd_data <= 8'h00;
        end else if (cfg_rd_en) begin
            case (cfg_addr)
                `HPC_OFF_CONFIG_BYTE_THREE: cfg_rd_data <= config_byte_three;
                `HPC_OFF_FIXED_PORT_MASK: cfg_rd_data <= fixed_port_mask;
                `HPC_OFF_SELF_POWERED_PORT_OFF_MASK: cfg_rd_data <= self_powered_port_off_mask;
                default: cfg_rd_data <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // apply phase
    // ----------------------------------------------------------------
    // one-way step: once loaded, settings are taken and held until reset
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state <= HPC_ST_LOADING;
        end else begin
            case (state)
                HPC_ST_LOADING: begin
                    if (config_done) begin
                        state <= HPC_ST_APPLIED;
                    end
                end
                HPC_ST_APPLIED: state <= HPC_ST_APPLIED;
                // a one-bit state has no spare code; the arm keeps the case complete
                default: state <= HPC_ST_LOADING;
            endcase
        end
    end

    // applied flag as its own flop so the port comes straight from a register
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            config_applied <= 1'b0;
        end else if (apply_now) begin
            config_applied <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // decoded setup
    // ----------------------------------------------------------------
    // host assignment interface decode, captured at the apply step
    // flags are one-hot except code 11, which raises both edge and unassigned; the switch logic needs no decode of its own
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            port_map_interface_mode <= 2'b00;
            map_three_wire <= 1'b0;
            map_level_sensitive <= 1'b0;
            map_edge_sensitive <= 1'b0;
            map_unassigned_allowed <= 1'b0;
            port_map_source_select <= 1'b0;
        end else if (apply_now) begin
            port_map_interface_mode <= hpc_map_field(config_byte_three);
            case (hpc_map_field(config_byte_three))
                HPC_MAP_PROGRAMMABLE: begin
                    map_three_wire <= 1'b1;
                    map_level_sensitive <= 1'b0;
                    map_edge_sensitive <= 1'b0;
                    map_unassigned_allowed <= 1'b0;
                end
                HPC_MAP_DIRECT_LEVEL: begin
                    map_three_wire <= 1'b0;
                    map_level_sensitive <= 1'b1;
                    map_edge_sensitive <= 1'b0;
                    map_unassigned_allowed <= 1'b0;
                end
                HPC_MAP_DIRECT_EDGE: begin
                    map_three_wire <= 1'b0;
                    map_level_sensitive <= 1'b0;
                    map_edge_sensitive <= 1'b1;
                    map_unassigned_allowed <= 1'b0;
                end
                default: begin
                    map_three_wire <= 1'b0;
                    map_level_sensitive <= 1'b0;
                    map_edge_sensitive <= 1'b1;
                    map_unassigned_allowed <= 1'b1;
                end
            endcase
            port_map_source_select <= config_byte_three[`HPC_MAP_SOURCE_BIT];
        end
    end

    // indicator and descriptor decode; 00 and 11 fold together
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ind_usb_mode <= 1'b0;
            ind_host_and_speed <= 1'b0;
            ind_host_only <= 1'b0;
            string_support_en <= 1'b0;
        end else if (apply_now) begin
            case (hpc_ind_field(config_byte_three))
                HPC_IND_HOST_SPEED: begin
                    ind_usb_mode <= 1'b0;
                    ind_host_and_speed <= 1'b1;
                    ind_host_only <= 1'b0;
                end
                HPC_IND_HOST_ONLY: begin
                    ind_usb_mode <= 1'b0;
                    ind_host_and_speed <= 1'b0;
                    ind_host_only <= 1'b1;
                end
                default: begin
                    ind_usb_mode <= 1'b1;
                    ind_host_and_speed <= 1'b0;
                    ind_host_only <= 1'b0;
                end
            endcase
            string_support_en <= config_byte_three[`HPC_STRING_EN_BIT];
        end
    end

    // ----------------------------------------------------------------
    // port masks
    // ----------------------------------------------------------------
    // straps stand in for the registers under internal defaults
    // port_fixed is the non-removable report handed to the host
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            port_fixed <= 4'h0;
            applied_off <= 4'h0;
        end else if (apply_now) begin
            if (use_internal_default) begin
                port_fixed <= hpc_low_ports(fixed_strap_stable);
                applied_off <= hpc_high_ports(off_strap_stable);
            end else begin
                port_fixed <= fixed_port_mask[4:1];
                applied_off <= self_powered_port_off_mask[4:1];
            end
        end
    end

    // disable mask only bites in self-powered operation
    // trade-off: gating is live, so a later move to self power takes effect on the next clock
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            port_off <= 4'h0;
        end else begin
            port_off <= applied_off & {4{self_powered & config_applied}};
        end
    end

endmodule : hpc_port_config_regs

`default_nettype wire

// ### verif/hpc_port_config_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none

module hpc_port_config_regs_chk (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // loader side
    input wire logic cfg_wr_en,
    input wire logic cfg_rd_en,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wr_data,
    input wire logic [7:0] cfg_rd_data,
    input wire logic config_done,
    input wire logic self_powered,
    // applied setup
    input wire logic [1:0] port_map_interface_mode,
    input wire logic map_three_wire,
    input wire logic map_level_sensitive,
    input wire logic map_edge_sensitive,
    input wire logic map_unassigned_allowed,
    input wire logic ind_usb_mode,
    input wire logic ind_host_and_speed,
    input wire logic ind_host_only,
    input wire logic string_support_en,
    input wire logic [3:0] port_fixed,
    input wire logic [3:0] port_off,
    input wire logic config_applied
);
    // ------------------------------------------------------------
    // all checks live in the core clock domain
    // ------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);

    three_wire_a: assert property (config_applied |-> map_three_wire == (port_map_interface_mode == 2'h0)) else $error("three-wire decode wrong");
    level_mode_a: assert property (config_applied |-> map_level_sensitive == (port_map_interface_mode == 2'h1)) else $error("level decode wrong");
    edge_mode_a: assert property (config_applied |-> map_edge_sensitive == port_map_interface_mode[1]) else $error("edge decode wrong");
    unassigned_mode_a: assert property (config_applied |-> map_unassigned_allowed == (port_map_interface_mode == 2'h3)) else $error("unassigned decode wrong");
    indicator_onehot_a: assert property (config_applied |-> $onehot({ind_usb_mode, ind_host_and_speed, ind_host_only})) else $error("indicator not one-hot");
    cfg3_reserved_a: assert property (cfg_rd_en && cfg_addr == 8'h08 |=> cfg_rd_data[4:3] == 2'h0) else $error("reserved bits of byte three set");
    mask_reserved_a: assert property (cfg_rd_en && (cfg_addr == 8'h09 || cfg_addr == 8'h0A) |=> (cfg_rd_data & 8'hE1) == 8'h00) else $error("reserved mask bits set");
    unmapped_read_a: assert property (cfg_rd_en && (cfg_addr < 8'h08 || cfg_addr > 8'h0A) |=> cfg_rd_data == 8'h00) else $error("unmapped read not zero");
    fixed_readback_a: assert property (cfg_wr_en && !config_applied && cfg_addr == 8'h09 ##1 cfg_rd_en && !cfg_wr_en && cfg_addr == 8'h09
        |=> cfg_rd_data == ($past(cfg_wr_data, 2) & 8'h1E)) else $error("fixed mask readback wrong");
    apply_once_a: assert property (config_done && !config_applied |=> config_applied) else $error("settings not applied");
    held_fixed_a: assert property (config_applied && $past(config_applied) |-> $stable(port_map_interface_mode) && $stable(port_fixed)
        && $stable(string_support_en)) else $error("settings moved after apply");
    off_gated_a: assert property (!self_powered ##1 !self_powered |-> port_off == 4'h0) else $error("port off outside self-powered");
endmodule : hpc_port_config_regs_chk

bind hpc_port_config_regs hpc_port_config_regs_chk hpc_port_config_regs_chk_inst (.mclk, .reset_n, .cfg_wr_en,
    .cfg_rd_en, .cfg_addr, .cfg_wr_data, .cfg_rd_data, .config_done, .self_powered, .port_map_interface_mode,
    .map_three_wire, .map_level_sensitive, .map_edge_sensitive, .map_unassigned_allowed, .ind_usb_mode,
    .ind_host_and_speed, .ind_host_only, .string_support_en, .port_fixed, .port_off, .config_applied);

`default_nettype wire

// ### verif/hpc_port_config_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none

module hpc_port_config_regs_tb;
    import hpc_pkg::*;
    logic mclk = 0, reset_n = 0, cfg_wr_en = 0, cfg_rd_en = 0, use_internal_default = 0;
    logic config_done = 0, self_powered = 0, map_three_wire, map_level_sensitive, map_edge_sensitive;
    logic map_unassigned_allowed, port_map_source_select, ind_usb_mode, ind_host_and_speed;
    logic ind_host_only, string_support_en, config_applied;
    logic [7:0] cfg_addr = 0, cfg_wr_data = 0, cfg_rd_data, cfg3;
    logic [1:0] fixed_port_strap = 0, port_off_strap = 0, port_map_interface_mode;
    logic [3:0] port_fixed, port_off, fix4, off4;
    logic [2:0] k;
    int failures = 0, checked = 0, cycles = 0;

    always #4 mclk = ~mclk;

    hpc_port_config_regs hpc_port_config_regs_inst (.mclk, .reset_n, .cfg_wr_en, .cfg_rd_en,
        .cfg_addr, .cfg_wr_data, .cfg_rd_data, .use_internal_default, .config_done, .self_powered,
        .fixed_port_strap, .port_off_strap, .port_map_interface_mode, .map_three_wire,
        .map_level_sensitive, .map_edge_sensitive, .map_unassigned_allowed, .port_map_source_select,
        .ind_usb_mode, .ind_host_and_speed, .ind_host_only, .string_support_en, .port_fixed,
        .port_off, .config_applied);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic final_report();
        if (failures == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : final_report

    // hang guard, generous against the few hundred cycles really needed
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            final_report();
        end
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // strobes are single-cycle pulses launched at the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk) {cfg_wr_en, cfg_addr, cfg_wr_data} = {1'b1, a, d};
        @(negedge mclk) cfg_wr_en = 0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge mclk) {cfg_rd_en, cfg_addr} = {1'b1, a};
        @(negedge mclk) cfg_rd_en = 0;
        check("read data", cfg_rd_data, exp);
    endtask : rd

    // write, then read the same offset in the very next cycle
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
        @(negedge mclk) {cfg_wr_en, cfg_addr, cfg_wr_data} = {1'b1, a, d};
        @(negedge mclk) {cfg_wr_en, cfg_rd_en} = 2'b01;
        @(negedge mclk) cfg_rd_en = 0;
        check("write-read", cfg_rd_data, exp);
    endtask : wr_rd

    function automatic logic [3:0] fix_dec(input logic [1:0] s);
        return 4'(4'h7 >> (2'h3 - s));
    endfunction : fix_dec

    function automatic logic [3:0] off_dec(input logic [1:0] s);
        return 4'(4'hE << (2'h3 - s));
    endfunction : off_dec

    // ------------------------------------------------------------
    // every mode code, both mask sources, with reserved bits poked
    // ------------------------------------------------------------
    initial begin
        for (int i = 0; i < 8; i++) begin
            k = 3'(i);
            {use_internal_default, fixed_port_strap, port_off_strap} = {k[2], k[1:0], ~k[1:0]};
            {self_powered, config_done, reset_n} = 3'b000;
            repeat (4) @(negedge mclk);
            reset_n = 1;
            rd(8'h08, 8'h00);
            rd(8'h09, 8'h00);
            rd(8'h0A, 8'h00);
            cfg3 = {k[1:0], k[0], 2'b11, k[1:0], k[2]}; // full lamp pin set assumed
            fix4 = fix_dec(k[1:0]) ^ 4'hA;
            off4 = off_dec(k[1:0]); // contiguous down from port 4
            wr(8'h08, cfg3);
            wr_rd(8'h09, {3'h7, fix4, 1'b1}, {3'h0, fix4, 1'b0});
            wr(8'h0A, {3'h7, off4, 1'b1});
            wr(8'h0B, 8'hFF);
            rd(8'h08, cfg3 & 8'hE7);
            rd(8'h09, {3'h0, fix4, 1'b0});
            rd(8'h0A, {3'h0, off4, 1'b0});
            rd(8'h0B, 8'h00);
            @(negedge mclk) config_done = 1;
            repeat (2) @(negedge mclk);
            check("applied", config_applied, 8'h01);
            check("map mode", port_map_interface_mode, k[1:0]);
            check("three wire", map_three_wire, k[1:0] == 0);
            check("level", map_level_sensitive, k[1:0] == 1);
            check("edge", map_edge_sensitive, k[1]);
            check("unassigned", map_unassigned_allowed, k[1:0] == 3);
            check("source", port_map_source_select, k[0]);
            check("ind usb", ind_usb_mode, k[1:0] == 0 || k[1:0] == 3);
            check("ind speed", ind_host_and_speed, k[1:0] == 1);
            check("ind host", ind_host_only, k[1:0] == 2);
            check("strings", string_support_en, k[2]);
            check("fixed", port_fixed, k[2] ? fix_dec(k[1:0]) : fix4);
            check("off bus", port_off, 8'h00);
            self_powered = 1;
            repeat (2) @(negedge mclk);
            check("off self", port_off, k[2] ? off_dec(~k[1:0]) : off4);
            wr(8'h09, 8'h00);
            rd(8'h09, {3'h0, fix4, 1'b0});
            check("fixed held", port_fixed, k[2] ? fix_dec(k[1:0]) : fix4);
        end
        final_report();
    end
endmodule : hpc_port_config_regs_tb

`default_nettype wire
